// [include/dtc_pkg.sv]
/*
 * Shared constants, field layouts and types for the DDR3 timing controller
 * and the memory-side timing model.
 * Assumes a 50 MHz system clock; the link clock is a divided copy of it.
 */
package dtc_pkg;
    // System clock and link clock division
    localparam int CLK_NS = 20;
    localparam int CK_DIV = 8;
    localparam int CK_NS = CLK_NS * CK_DIV;
    localparam int TW = 8;

    // Least time in whole cycles, rounded up, never below one
    function automatic logic [TW-1:0] cyc_up(real ns, int per);
        int c;
        c = int'($ceil(ns / per));
        return TW'((c < 1) ? 1 : c);
    endfunction

    // Longest time in whole cycles, rounded down, never below one
    function automatic logic [TW-1:0] cyc_dn(real ns, int per);
        int c;
        c = int'($floor(ns / per));
        return TW'((c < 1) ? 1 : c);
    endfunction

    // Spacing figures in their own units
    localparam real T_RFC_NS = 160.0;
    localparam real T_REFI_NOM_US = 7.8;
    localparam real T_REFI_HOT_US = 3.9;
    localparam real T_WR_NS = 15.0;
    localparam real T_AONPD_MIN_NS = 2.0;
    localparam real T_WLO_MAX_NS = 7.5;
    localparam logic [TW-1:0] T_RFC_CK = cyc_up(T_RFC_NS, CK_NS);
    localparam logic [TW-1:0] T_REFI_NOM_CK = cyc_dn(T_REFI_NOM_US * 1000.0, CK_NS);
    localparam logic [TW-1:0] T_REFI_HOT_CK = cyc_dn(T_REFI_HOT_US * 1000.0, CK_NS);
    localparam logic [TW-1:0] T_WR_CK = cyc_up(T_WR_NS, CK_NS);
    localparam logic [TW-1:0] T_AONPD_CLK = cyc_up(T_AONPD_MIN_NS, CLK_NS);
    localparam logic [TW-1:0] T_WLO_CLK = cyc_dn(T_WLO_MAX_NS, CLK_NS);
    localparam logic [TW-1:0] T_MOD_CK = 8'h0c;
    localparam logic [TW-1:0] T_REFPDEN_CK = 8'h01;
    localparam logic [TW-1:0] ODTH4_CK = 8'h04;
    localparam logic [TW-1:0] ODTH8_CK = 8'h06;
    localparam logic [TW-1:0] WLMRD_CK = 8'h28;
    localparam logic [TW-1:0] WLDQSEN_CK = 8'h19;
    localparam logic [TW-1:0] BL8_EXT = 8'h04;
    localparam logic [TW-1:0] BC4_EXT = 8'h02;
    localparam logic [TW-1:0] ODTL_SUB = 8'h02;
    localparam logic [TW-1:0] WRA_EXTRA = 8'h01;

    // Register port
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_TIM = 4'h4;
    localparam logic [ADDR_W-1:0] REG_CMD = 4'h8;
    localparam logic [ADDR_W-1:0] REG_STAT = 4'hc;
    localparam int CTRL_REF_EN = 0;
    localparam int CTRL_HOT = 1;
    localparam int CTRL_DLL = 2;
    localparam int CTRL_PD = 3;
    localparam int CTRL_ODT = 4;
    localparam int CTRL_W = 5;
    localparam int TIM_WL_LSB = 0;
    localparam int TIM_WR_LSB = 4;
    localparam int TIM_BM_LSB = 8;
    localparam int CMD_BC4 = 3;
    localparam int CMD_WLV = 4;
    localparam logic [3:0] TIM_RESET_WL = 4'h5;
    localparam logic [3:0] TIM_RESET_WR = 4'h5;

    // Mode word carried on MRS: {leveling, burst mode, WL}
    localparam int MR_WL_LSB = 0;
    localparam int MR_BM_LSB = 4;
    localparam int MR_WLV = 6;
    localparam int MR_W = 7;

    typedef enum logic [2:0] {CMD_NOP, CMD_MRS, CMD_REF, CMD_ACT, CMD_WR, CMD_WRA, CMD_RD, CMD_PRE} dtc_cmd_t;
    typedef enum logic [1:0] {BM_BL8, BM_OTF, BM_BC4} dtc_bm_t;
endpackage

// [include/dtc_link_if.sv]
/*
 * Link between controller and memory: clock, CKE, ODT, command, mode word,
 * strobe and the leveling feedback.
 * Assumes the controller end makes the link clock from its own clock.
 */
`timescale 1ns/10ps
interface dtc_link_if;
    import dtc_pkg::*;
    logic ck;               // Link clock, made by the controller
    logic cke;              // Clock enable, low for power-down
    logic odt;              // Termination request
    dtc_cmd_t cmd;          // Command, sampled on ck rising
    logic bc4;              // On-the-fly chop for writes
    logic [MR_W-1:0] mr;    // Mode word for MRS
    logic dqs_en;           // Strobe drive enabled
    logic dqs;              // Strobe level
    logic dq_fb;            // Sampled clock level in leveling
    modport ctrl (output ck, cke, odt, cmd, bc4, mr, dqs_en, dqs, input dq_fb);
    modport dev (input ck, cke, odt, cmd, bc4, mr, dqs_en, dqs, output dq_fb);
endinterface

// [core/dtc_timer.sv]
/*
 * Down-counter that blocks a dependent command until it expires.
 * Assumes one decrement enable per link clock from the caller.
 */
`timescale 1ns/10ps
module dtc_timer import dtc_pkg::*; #(
    parameter int W = TW
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_tick,
    input wire logic i_load,
    input wire logic [W-1:0] i_value,
    output logic o_busy
);
    logic [W-1:0] cnt_q; // Remaining cycles

    // Load keeps the longer of old and new spacing
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            cnt_q <= '0;
        else if (i_load && i_value > cnt_q)
            cnt_q <= i_value;
        else if (i_tick && cnt_q != '0)
            cnt_q <= cnt_q - W'(1);
    end

    assign o_busy = (cnt_q != '0);
endmodule

// [core/dtc_ctrl.sv]
/*
 * Controller end: issues commands, CKE, ODT and leveling strobe while
 * keeping every spacing in link clock cycles.
 * Assumes a 50 MHz i_clk and software on the plain register port.
 */
`timescale 1ns/10ps
module dtc_ctrl import dtc_pkg::*; (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    dtc_link_if.ctrl link
);
    localparam int DIV_W = $clog2(CK_DIV);
    localparam logic [TW-1:0] REF_LEAD = 8'h01; // Wake lead ahead of a due refresh, in clocks

    logic [DIV_W-1:0] div_q;         // Link clock phase
    logic ck_q;                      // Link clock out
    logic tick_rise;                 // Link clock about to rise
    logic tick_fall;                 // Link clock about to fall
    logic [CTRL_W-1:0] ctrl_q;       // Control bits
    logic [3:0] wl_q;                // Write latency in clocks
    logic [3:0] wrck_q;              // WR as programmed
    dtc_bm_t bm_q;                   // Burst mode
    logic pend_q;                    // Command waiting
    dtc_cmd_t pcode_q;               // Waiting command
    logic pbc4_q;                    // Waiting chop flag
    logic pwl_q;                     // Waiting leveling flag
    dtc_cmd_t cmd_q;                 // Command on the link
    logic cke_q;                     // CKE on the link
    logic odt_q;                     // ODT on the link
    logic bc4_q;                     // Chop flag on the link
    logic [MR_W-1:0] mr_q;           // Mode word on the link
    logic wl_act_q;                  // Leveling mode active
    logic dqs_en_q;                  // Strobe drive enabled
    logic dqs_q;                     // Strobe level
    logic dqs_done_q;                // Leveling edge sent
    logic wl_res_q;                  // Leveling result
    logic fb_m_q;                    // Feedback, first stage
    logic fb_s_q;                    // Feedback, second stage
    logic [31:0] rdata_q;            // Read data
    logic pde_busy, rfc_busy, refi_busy, odth_busy, wlen_busy, wlmrd_busy;
    logic refw_busy;                 // Refresh not yet within one clock
    logic ref_due, ref_go, cmd_ok, pd_go, wake, issue, burst8, odt_up, odt_dn;
    dtc_cmd_t icode;                 // Command being issued
    logic [TW-1:0] pde_val;          // Power-down spacing for icode
    logic [TW-1:0] ext;              // Burst tail after WL

    // Link clock divider; rise and fall are one-cycle enables
    assign tick_rise = (div_q == DIV_W'(CK_DIV - 1));
    assign tick_fall = (div_q == DIV_W'(CK_DIV / 2 - 1));

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            div_q <= '0;
        else
            div_q <= tick_rise ? '0 : div_q + DIV_W'(1);
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            ck_q <= 1'b0;
        else if (tick_rise)
            ck_q <= 1'b1;
        else if (tick_fall)
            ck_q <= 1'b0;
    end

    // Software registers
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ctrl_q <= '0;
            wl_q <= TIM_RESET_WL;
            wrck_q <= TIM_RESET_WR;
            bm_q <= BM_BL8;
        end
        else if (i_wr && i_addr == REG_CTRL)
            ctrl_q <= i_wdata[CTRL_W-1:0];
        else if (i_wr && i_addr == REG_TIM)
        begin
            wl_q <= i_wdata[TIM_WL_LSB +: 4];
            wrck_q <= i_wdata[TIM_WR_LSB +: 4];
            bm_q <= dtc_bm_t'(i_wdata[TIM_BM_LSB +: 2]);
        end
    end

    // Command slot; a write while one waits is ignored
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pend_q <= 1'b0;
            pcode_q <= CMD_NOP;
            pbc4_q <= 1'b0;
            pwl_q <= 1'b0;
        end
        else if (issue && !ref_go)
            pend_q <= 1'b0;
        else if (i_wr && i_addr == REG_CMD && !pend_q)
        begin
            pend_q <= 1'b1;
            pcode_q <= dtc_cmd_t'(i_wdata[2:0]);
            pbc4_q <= i_wdata[CMD_BC4];
            pwl_q <= i_wdata[CMD_WLV];
        end
    end

    // Issue decision; refresh outranks the waiting command
    assign ref_due = ctrl_q[CTRL_REF_EN] && !refi_busy;
    assign ref_go = ref_due && cke_q && !rfc_busy;
    always_comb
    begin
        cmd_ok = pend_q && cke_q && !ref_due;
        unique case (pcode_q)
            CMD_ACT, CMD_REF: cmd_ok = cmd_ok && !rfc_busy;
            CMD_RD: cmd_ok = cmd_ok && ctrl_q[CTRL_DLL];
            default: cmd_ok = cmd_ok;
        endcase
    end
    assign issue = tick_fall && (ref_go || cmd_ok);
    assign icode = ref_go ? CMD_REF : pcode_q;
    assign pd_go = ctrl_q[CTRL_PD] && cke_q && !pend_q && !ref_due && !pde_busy && !wl_act_q &&
        (refw_busy || !ctrl_q[CTRL_REF_EN]);
    // Wake a clock ahead of refresh, so power-down never makes it late
    assign wake = !cke_q && (!ctrl_q[CTRL_PD] || pend_q || ref_due ||
        (ctrl_q[CTRL_REF_EN] && !refw_busy));

    // Power-down spacing for the command being issued
    assign ext = (bm_q == BM_BC4) ? BC4_EXT : BL8_EXT;
    always_comb
    begin
        unique case (icode)
            CMD_WR: pde_val = TW'(wl_q) + ext + T_WR_CK;
            CMD_WRA: pde_val = TW'(wl_q) + ext + TW'(wrck_q) + WRA_EXTRA;
            CMD_REF: pde_val = T_REFPDEN_CK;
            CMD_MRS: pde_val = T_MOD_CK;
            default: pde_val = '0;
        endcase
    end

    // Link command, CKE and mode word, launched on the falling edge
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cmd_q <= CMD_NOP;
            cke_q <= 1'b1;
            bc4_q <= 1'b0;
            mr_q <= '0;
        end
        else if (tick_fall)
        begin
            cmd_q <= issue ? icode : CMD_NOP;
            if (pd_go)
                cke_q <= 1'b0;
            else if (wake)
                cke_q <= 1'b1;
            if (issue)
                bc4_q <= pbc4_q;
            if (issue && icode == CMD_MRS)
                mr_q <= {pwl_q, bm_q, wl_q};
        end
    end

    // ODT: rises only with locked DLL, falls after the hold time
    assign odt_up = !odt_q && ctrl_q[CTRL_ODT] && ctrl_q[CTRL_DLL] && cke_q;
    assign odt_dn = odt_q && !ctrl_q[CTRL_ODT] && !odth_busy;
    assign burst8 = (bm_q == BM_BL8) || (bm_q == BM_OTF && !pbc4_q);

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            odt_q <= 1'b0;
        else if (tick_fall && odt_up)
            odt_q <= 1'b1;
        else if (tick_fall && odt_dn)
            odt_q <= 1'b0;
    end

    // Leveling mode follows the leveling flag of each MRS
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            wl_act_q <= 1'b0;
        else if (issue && icode == CMD_MRS)
            wl_act_q <= pwl_q;
    end

    // Strobe enable and single edge, launched on the rising edge
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            dqs_en_q <= 1'b0;
            dqs_q <= 1'b0;
            dqs_done_q <= 1'b0;
        end
        else if (!wl_act_q)
        begin
            dqs_en_q <= 1'b0;
            dqs_q <= 1'b0;
            dqs_done_q <= 1'b0;
        end
        else if (tick_rise)
        begin
            dqs_en_q <= dqs_en_q || !wlen_busy;
            if (!wlmrd_busy && dqs_en_q && !dqs_done_q)
            begin
                dqs_q <= 1'b1;
                dqs_done_q <= 1'b1;
            end
        end
        else if (tick_fall)
            dqs_q <= 1'b0;
    end

    // Feedback crosses in from the link
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            fb_m_q <= 1'b0;
            fb_s_q <= 1'b0;
            wl_res_q <= 1'b0;
        end
        else
        begin
            fb_m_q <= link.dq_fb;
            fb_s_q <= fb_m_q;
            if (wl_act_q && dqs_done_q)
                wl_res_q <= fb_s_q;
        end
    end

    // One counter per spacing
    dtc_timer u_pde (.i_clk(i_clk), .i_reset(i_reset), .i_tick(tick_rise),
        .i_load(issue), .i_value(pde_val), .o_busy(pde_busy));
    dtc_timer u_rfc (.i_clk(i_clk), .i_reset(i_reset), .i_tick(tick_rise),
        .i_load(issue && icode == CMD_REF), .i_value(T_RFC_CK), .o_busy(rfc_busy));
    dtc_timer u_refi (.i_clk(i_clk), .i_reset(i_reset), .i_tick(tick_rise),
        .i_load(issue && icode == CMD_REF), .o_busy(refi_busy),
        .i_value(ctrl_q[CTRL_HOT] ? T_REFI_HOT_CK : T_REFI_NOM_CK));
    dtc_timer u_refw (.i_clk(i_clk), .i_reset(i_reset), .i_tick(tick_rise),
        .i_load(issue && icode == CMD_REF), .o_busy(refw_busy),
        .i_value((ctrl_q[CTRL_HOT] ? T_REFI_HOT_CK : T_REFI_NOM_CK) - REF_LEAD));
    dtc_timer u_odth (.i_clk(i_clk), .i_reset(i_reset), .i_tick(tick_rise), .o_busy(odth_busy),
        .i_load(tick_fall && (odt_up || (issue && (icode == CMD_WR || icode == CMD_WRA)))),
        .i_value((!odt_up && burst8) ? ODTH8_CK : ODTH4_CK));
    dtc_timer u_wlen (.i_clk(i_clk), .i_reset(i_reset), .i_tick(tick_rise),
        .i_load(issue && icode == CMD_MRS), .i_value(WLDQSEN_CK), .o_busy(wlen_busy));
    dtc_timer u_wlmrd (.i_clk(i_clk), .i_reset(i_reset), .i_tick(tick_rise),
        .i_load(issue && icode == CMD_MRS), .i_value(WLMRD_CK), .o_busy(wlmrd_busy));

    // Read data stand one cycle after the strobe only
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            rdata_q <= '0;
        else if (!i_rd)
            rdata_q <= '0;
        else
        begin
            unique case (i_addr)
                REG_CTRL: rdata_q <= 32'(ctrl_q);
                REG_TIM: rdata_q <= 32'({bm_q, wrck_q, wl_q});
                REG_STAT: rdata_q <= 32'({wl_res_q, wl_act_q, !cke_q, ref_due, pend_q});
                default: rdata_q <= '0;
            endcase
        end
    end

    assign o_rdata = rdata_q;
    assign link.ck = ck_q;
    assign link.cke = cke_q;
    assign link.odt = odt_q;
    assign link.cmd = cmd_q;
    assign link.bc4 = bc4_q;
    assign link.mr = mr_q;
    assign link.dqs_en = dqs_en_q;
    assign link.dqs = dqs_q;
endmodule

// [core/dtc_dev.sv]
/*
 * Memory end: termination latency, power-down termination, dynamic
 * termination window, internal write start and leveling feedback.
 * Assumes the link clock is much slower than i_clk and is sampled by it.
 */
`timescale 1ns/10ps
module dtc_dev import dtc_pkg::*; (
    input wire logic i_clk,
    input wire logic i_reset,
    dtc_link_if.dev link,
    output logic o_rtt_nom,
    output logic o_rtt_wr,
    output logic o_wr_start,
    output logic o_refresh,
    output logic o_pd,
    output logic o_wl_mode
);
    localparam int SW = 8 + MR_W;
    localparam int PIPE = 16;

    logic [SW-1:0] m_q, s_q;          // Two-stage synchroniser
    logic ck_s, cke_s, odt_s, bc4_s, dqs_s;
    dtc_cmd_t cmd_s;
    logic [MR_W-1:0] mr_s;
    logic ck_p_q, dqs_p_q, rise, fall;
    logic cke_q;                      // CKE as registered
    logic [MR_W-1:0] mr_q;            // Stored mode word
    logic [PIPE-1:0] pipe_q;          // ODT history per clock
    logic [TW-1:0] lat;               // Termination latency
    logic nom_tgt, tgt_q, chop, wr_cmd;
    logic [TW-1:0] wrw_q, dur_q, ws_q;
    logic fb_q, ws_pulse_q, ref_q;

    // All link inputs but dqs_en cross two flip-flops
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            m_q <= '0;
            s_q <= '0;
        end
        else
        begin
            m_q <= {link.ck, link.cke, link.odt, link.bc4, link.dqs, link.cmd, link.mr};
            s_q <= m_q;
        end
    end
    assign {ck_s, cke_s, odt_s, bc4_s, dqs_s} = s_q[SW-1 -: 5];
    assign cmd_s = dtc_cmd_t'(s_q[MR_W +: 3]);
    assign mr_s = s_q[MR_W-1:0];

    // Edge finding on the sampled link clock
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ck_p_q <= 1'b0;
            dqs_p_q <= 1'b0;
        end
        else
        begin
            ck_p_q <= ck_s;
            dqs_p_q <= dqs_s;
        end
    end
    assign rise = ck_s && !ck_p_q;
    assign fall = !ck_s && ck_p_q;
    assign wr_cmd = cke_q && (cmd_s == CMD_WR || cmd_s == CMD_WRA);
    assign chop = (mr_q[MR_BM_LSB +: 2] == BM_BC4) || (mr_q[MR_BM_LSB +: 2] == BM_OTF && bc4_s);
    assign lat = TW'(mr_q[MR_WL_LSB +: 4]) - ODTL_SUB;
    assign nom_tgt = (lat == '0) ? odt_s : pipe_q[lat[3:0] - 4'h1];

    // Registered CKE, mode word and ODT history
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cke_q <= 1'b1;
            mr_q <= '0;
            pipe_q <= '0;
            tgt_q <= 1'b0;
        end
        else if (rise)
        begin
            cke_q <= cke_s;
            if (cke_q && cmd_s == CMD_MRS)
                mr_q <= mr_s;
            pipe_q <= {pipe_q[PIPE-2:0], odt_s};
            tgt_q <= nom_tgt;
        end
    end

    // Nominal termination: on at latency, off half a clock later
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            o_rtt_nom <= 1'b0;
        else if (!cke_q)
            o_rtt_nom <= odt_s;
        else if (rise && nom_tgt)
            o_rtt_nom <= 1'b1;
        else if (fall && !tgt_q)
            o_rtt_nom <= 1'b0;
    end

    // Write termination window, changed on the half clock
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            wrw_q <= '0;
            dur_q <= '0;
            o_rtt_wr <= 1'b0;
        end
        else
        begin
            if (rise && wr_cmd)
            begin
                dur_q <= chop ? ODTH4_CK : ODTH8_CK;
                wrw_q <= lat + (chop ? ODTH4_CK : ODTH8_CK);
            end
            else if (rise && wrw_q != '0)
                wrw_q <= wrw_q - TW'(1);
            if (fall)
                o_rtt_wr <= (wrw_q != '0) && (wrw_q <= dur_q);
        end
    end

    // Internal write start after WL plus burst tail
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ws_q <= '0;
            ws_pulse_q <= 1'b0;
        end
        else
        begin
            ws_pulse_q <= rise && ws_q == TW'(1);
            if (rise && wr_cmd)
                ws_q <= TW'(mr_q[MR_WL_LSB +: 4]) +
                    ((mr_q[MR_BM_LSB +: 2] == BM_BC4) ? BC4_EXT : BL8_EXT);
            else if (rise && ws_q != '0)
                ws_q <= ws_q - TW'(1);
        end
    end

    // Refresh pulse and leveling feedback within one cycle
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ref_q <= 1'b0;
            fb_q <= 1'b0;
        end
        else
        begin
            ref_q <= rise && cke_q && cmd_s == CMD_REF;
            if (!mr_q[MR_WLV])
                fb_q <= 1'b0;
            else if (dqs_s && !dqs_p_q)
                fb_q <= ck_s;
        end
    end

    assign o_wr_start = ws_pulse_q;
    assign o_refresh = ref_q;
    assign o_pd = !cke_q;
    assign o_wl_mode = mr_q[MR_WLV];
    assign link.dq_fb = fb_q;
endmodule

// [tb/dtc_monitor.sv]
/* Link checker: command spacing seen on the wires between both ends.
   Assumes cmd, cke and odt change on the i_clk edge where ck falls. */
`timescale 1ns/10ps
module dtc_monitor import dtc_pkg::*; #(
    parameter int WR_CK = 5
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic ck,
    input wire logic cke,
    input wire logic odt,
    input wire dtc_cmd_t cmd,
    input wire logic [MR_W-1:0] mr,
    input wire logic dqs_en,
    input wire logic dqs
);
    logic ck_q, slot;
    logic [15:0] ref_n, mrs_n, wra_n, lvl_n, odt_n; // Ages in i_clk
    logic [MR_W-1:0] mode_q; // Last mode word sent
    int need;
    // Saturates, so an absent trigger never fires a check
    function automatic logic [15:0] inc(input logic [15:0] x);
        return (x == 16'hffff) ? x : x + 16'h1;
    endfunction
    assign slot = ck_q & ~ck;
    assign need = (int'(mode_q[3:0]) + ((mode_q[5:4] == 2'h2) ? 2 : 4) + WR_CK + 1) * 8 - 1;
    // Ages since each trigger slot
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ck_q <= 1'b0;
            {ref_n, mrs_n, wra_n, lvl_n} <= {4{16'hffff}};
            odt_n <= 16'h0;
            mode_q <= 7'h0;
        end
        else
        begin
            ck_q <= ck;
            ref_n <= (slot && cmd == CMD_REF) ? 16'h0 : inc(ref_n);
            mrs_n <= (slot && cmd == CMD_MRS) ? 16'h0 : inc(mrs_n);
            wra_n <= (slot && cmd == CMD_WRA) ? 16'h0 : inc(wra_n);
            lvl_n <= (slot && cmd == CMD_MRS && mr[MR_WLV]) ? 16'h0 : inc(lvl_n);
            odt_n <= odt ? inc(odt_n) : 16'h0;
            if (slot && cmd == CMD_MRS)
                mode_q <= mr;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    chk_wra_pd_gap: assert property ($fell(cke) |-> int'(wra_n) >= need) else $error("wra to pd short");
    chk_ref_pd_gap: assert property ($fell(cke) |-> ref_n >= 16'h7) else $error("ref to pd short");
    chk_mrs_pd_gap: assert property ($fell(cke) |-> mrs_n >= 16'h5f) else $error("mrs to pd short");
    chk_odt_hold: assert property ($fell(odt) |-> odt_n >= 16'h20) else $error("odt high short");
    chk_ref_space: assert property (slot && cmd inside {CMD_REF, CMD_ACT} |-> ref_n >= 16'h7) else $error("rfc");
    chk_ref_interval: assert property (slot && cmd == CMD_REF |-> ref_n <= 16'h17f || ref_n == 16'hffff)
        else $error("refresh late");
    chk_dqs_en_wait: assert property ($rose(dqs_en) |-> lvl_n >= 16'hc7) else $error("strobe on early");
    chk_dqs_first: assert property ($rose(dqs) |-> lvl_n >= 16'h13f) else $error("strobe edge early");
    cover property (slot && cmd == CMD_WRA);
    cover property ($fell(cke));
    cover property ($rose(dqs));
endmodule

// [tb/tb_top.sv]
/* Bench for the DDR3 timing pair: both ends joined by one link.
   Assumes the register port is the only stimulus; expectations come from link clock counts. */
`timescale 1ns/10ps
module tb_top;
    import dtc_pkg::*;
    logic i_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [ADDR_W-1:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, v;
    logic o_rtt_nom, o_rtt_wr, o_wr_start, o_refresh, o_pd, o_wl_mode;
    logic [8:0] ev; // Watched events by index
    int fails = 0, samples_checked = 0, rises = 0, r0, wl;
    dtc_link_if link();
    dtc_ctrl dtc_ctrl_inst(.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .link(link));
    dtc_dev dtc_dev_inst(.i_clk, .i_reset, .link(link), .o_rtt_nom, .o_rtt_wr, .o_wr_start, .o_refresh, .o_pd,
        .o_wl_mode);
    dtc_monitor dtc_monitor_inst(.i_clk, .i_reset, .ck(link.ck), .cke(link.cke), .odt(link.odt), .cmd(link.cmd),
        .mr(link.mr), .dqs_en(link.dqs_en), .dqs(link.dqs));
    assign ev = {o_rtt_wr, link.dqs, link.dqs_en, o_wl_mode, o_pd, link.odt, o_rtt_nom, o_wr_start, o_refresh};
    always #10 i_clk = ~i_clk;
    // Link clock count is the model's time base
    always @(posedge link.ck) rises++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        v = o_rdata;
    endtask
    // Bounded wait on one event, then compare it
    task automatic wt(input int i, input logic x);
        for (int k = 0; k < 4000 && ev[i] !== x; k++)
            @(posedge i_clk);
        chk({31'h0, ev[i]}, {31'h0, x});
    endtask
    // Command slot seen on the link; r0 is the rise that registers it
    task automatic issue(input logic [31:0] c, input logic w);
        if (w)
            wr(REG_CMD, c);
        for (int k = 0; k < 4000 && link.cmd !== dtc_cmd_t'(c[2:0]); k++)
            @(posedge i_clk);
        chk({29'h0, link.cmd}, {29'h0, c[2:0]});
        r0 = rises + 1;
    endtask
    task automatic gap(input logic [31:0] n);
        wt(0, 1'b1);
        r0 = rises;
        @(posedge i_clk);
        wt(0, 1'b1);
        chk(32'(rises - r0), n);
    endtask
    task automatic test_done();
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #1000000;
        fails++;
        test_done();
    end
    initial
    begin
        void'($urandom(93));
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(REG_TIM);
        chk(v, 32'h55);
        rd(4'h2);
        chk(v, 32'h0);
        wr(REG_CTRL, 32'h5);
        gap(32'h30);
        wr(REG_CTRL, 32'h7);
        @(posedge i_clk);
        gap(32'h18);
        gap(32'h18);
        wr(REG_CTRL, 32'h5);
        // Every burst mode: write start, then power-down behind the write
        for (int b = 0; b < 3; b++)
        begin
            wl = 5 + $urandom % 4;
            wr(REG_TIM, 32'(b * 256 + 80 + wl));
            issue(32'h1, 1'b1);
            issue(32'h5, 1'b1);
            wt(8, 1'b1);
            chk(32'(rises - r0), 32'(wl - 2));
            wt(1, 1'b1);
            chk(32'(rises - r0), 32'(wl + ((b == 2) ? 2 : 4)));
            wt(8, 1'b0);
            chk(32'(rises - r0), 32'(wl - 2 + ((b == 2) ? 4 : 6)));
            wr(REG_CTRL, 32'hd);
            wt(4, 1'b1);
            wr(REG_CTRL, 32'h5);
            wt(4, 1'b0);
        end
        wr(REG_CTRL, 32'h15);
        wt(3, 1'b1);
        r0 = rises + 1;
        wt(2, 1'b1);
        chk(32'(rises - r0), 32'(wl - 2));
        wr(REG_CTRL, 32'h5);
        wt(3, 1'b0);
        // No lock: read and termination must both stay off
        wr(REG_CTRL, 32'h11);
        wr(REG_CMD, 32'h6);
        v = 32'h0;
        repeat (200)
        begin
            @(posedge i_clk);
            v[0] = v[0] | link.odt | (link.cmd == CMD_RD);
        end
        chk(v, 32'h0);
        wr(REG_CTRL, 32'h5);
        issue(32'h6, 1'b0);
        issue(32'h11, 1'b1);
        wt(5, 1'b1);
        wt(6, 1'b1);
        chk(32'(rises - r0 >= 25), 32'h1);
        wt(7, 1'b1);
        chk(32'(rises - r0 >= 40), 32'h1);
        // Feedback crosses two synchronisers before status holds it
        repeat (8) @(posedge i_clk);
        rd(REG_STAT);
        chk(v & 32'h8, 32'h8);
        chk(v & 32'h10, 32'h10);
        test_done();
    end
endmodule
